// [hdl/prs_cfg.svh]
// Constants for the reset sequencer and link status block.
`ifndef PRS_CFG_SVH
`define PRS_CFG_SVH
`define PRS_CLK_MHZ        100
`define PRS_CORE_DLY       32
`define PRS_TXLOCK_DLY     127
`define PRS_SIGDET_MS      3
`define PRS_SIGDET_CYC     (`PRS_SIGDET_MS * `PRS_CLK_MHZ * 1000)
`define PRS_RXDET_DONE     3'h3
`define PRS_OFS_SPEED      16'h0068
`define PRS_OFS_LANE       16'h006c
`define PRS_OFS_LTSSM      16'h0070
`define PRS_OFS_RESET      16'h0074
`define PRS_OFS_CTRL       16'h0078
`define PRS_LT_DQUIET      5'h00
`define PRS_LT_DACTIVE     5'h01
`define PRS_LT_PACTIVE     5'h03
`endif

// [hdl/prs_pkg.sv]
// Types for the reset sequencer and link status block.
package prs_pkg;
	typedef enum logic [1:0] {PRS_CR_WAIT, PRS_CR_COUNT, PRS_CR_DONE} prs_core_st_t;
	typedef enum logic [1:0] {PRS_LT_QUIET, PRS_LT_ACTIVE, PRS_LT_POLL} prs_lt_st_t;
	typedef struct packed {
		logic [1:0] speed;
		logic [3:0] lanes;
	} prs_link_t;
endpackage : prs_pkg

// [hdl/prs_top.sv]
// Reset sequencer with training-state tracking and AHB-Lite status registers.
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "prs_cfg.svh"
module prs_top
	import prs_pkg::*;
#(
	parameter int unsigned SIGDET_CYC = `PRS_SIGDET_CYC
)
(
	input  wire logic        hclk,            // Fabric clock, 100 MHz.
	input  wire logic        hresetn,         // Power-on reset, active low.
	input  wire logic        perst_n,         // Fundamental reset, active low.
	input  wire logic        clk_inuse,       // Fabric clock in use.
	input  wire logic        rx_pll_locked,   // Receive PLL lock.
	input  wire logic        pll_locked,      // Transmit PLL lock.
	input  wire logic        phystatus,       // PHY status pulse.
	input  wire logic [2:0]  rxstatus,        // PHY receive status.
	input  wire logic        rx_sigdet,       // Receive signal detect.
	input  wire prs_link_t   link_in,         // Negotiated speed and lanes.
	output logic             core_rst,        // Internal core resets.
	output logic             reset_status,    // Reset status to application.
	output logic             tx_xcvr_rst_n,   // Transmit transceiver reset, low active.
	output logic             tx_digital_rst,  // Transmit digital reset.
	output logic             rx_digital_rst,  // Receive digital reset.
	output logic [4:0]       ltssm_state,     // Training state code.
	input  wire logic        hsel,            // AHB select.
	input  wire logic [15:0] haddr,           // AHB address.
	input  wire logic [1:0]  htrans,          // AHB transfer type.
	input  wire logic        hwrite,          // AHB write.
	input  wire logic [2:0]  hsize,           // AHB size.
	input  wire logic [31:0] hwdata,          // AHB write data.
	input  wire logic        hready,          // AHB ready in.
	output logic [31:0]      hrdata,          // AHB read data.
	output logic             hreadyout,       // AHB ready out.
	output logic             hresp            // AHB response.
);
	logic [1:0]  in_sync_ff, lock_sync_ff, rxl_sync_ff, sd_sync_ff;
	prs_core_st_t core_st_ff;
	prs_lt_st_t  lt_st_ff;
	logic [5:0]  core_cnt_ff;
	logic [7:0]  tx_cnt_ff;
	logic [31:0] sd_cnt_ff;
	logic        sd_prev_ff;
	logic        ctrl_hold_ff;
	prs_link_t   link_ff;
	logic        wr_ph_ff;
	logic [15:0] wr_addr_ff;

	// Synchronizers; only the second stage is used by logic.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			in_sync_ff   <= 2'h0;
			lock_sync_ff <= 2'h0;
			rxl_sync_ff  <= 2'h0;
			sd_sync_ff   <= 2'h0;
		end
		else
		begin
			in_sync_ff   <= {in_sync_ff[0], clk_inuse & perst_n};
			lock_sync_ff <= {lock_sync_ff[0], pll_locked};
			rxl_sync_ff  <= {rxl_sync_ff[0], rx_pll_locked};
			sd_sync_ff   <= {sd_sync_ff[0], rx_sigdet};
		end
	end

	// Core reset sequence; a fundamental reset restarts it.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			core_st_ff  <= PRS_CR_WAIT;
			core_cnt_ff <= 6'h00;
		end
		else if (!in_sync_ff[1] || ctrl_hold_ff)
		begin
			core_st_ff  <= PRS_CR_WAIT;
			core_cnt_ff <= 6'h00;
		end
		else
		begin
			case (core_st_ff)
				PRS_CR_WAIT:
				begin
					core_st_ff  <= PRS_CR_COUNT;
					core_cnt_ff <= 6'h01;
				end
				PRS_CR_COUNT:
				begin
					if (core_cnt_ff == 6'(`PRS_CORE_DLY))
						core_st_ff <= PRS_CR_DONE;
					else
						core_cnt_ff <= core_cnt_ff + 6'h01;
				end
				PRS_CR_DONE:
					core_st_ff <= PRS_CR_DONE;
				default:
					core_st_ff <= PRS_CR_WAIT;
			endcase
		end
	end

	assign core_rst     = (core_st_ff != PRS_CR_DONE);
	assign reset_status = core_rst;
	assign tx_xcvr_rst_n = hresetn;

	// Transmit digital reset needs a long run of stable lock.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			tx_cnt_ff <= 8'h00;
		else if (!lock_sync_ff[1])
			tx_cnt_ff <= 8'h00;
		else if (tx_cnt_ff != 8'(`PRS_TXLOCK_DLY))
			tx_cnt_ff <= tx_cnt_ff + 8'h01;
	end
	assign tx_digital_rst = (tx_cnt_ff != 8'(`PRS_TXLOCK_DLY));

	// Training state tracking for the early states.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			lt_st_ff <= PRS_LT_QUIET;
		else if (core_rst)
			lt_st_ff <= PRS_LT_QUIET;
		else
		begin
			case (lt_st_ff)
				PRS_LT_QUIET:
					if (rxl_sync_ff[1])
						lt_st_ff <= PRS_LT_ACTIVE;
				PRS_LT_ACTIVE:
					if (phystatus && rxstatus == `PRS_RXDET_DONE)
						lt_st_ff <= PRS_LT_POLL;
				PRS_LT_POLL:
					if (!rxl_sync_ff[1])
						lt_st_ff <= PRS_LT_QUIET;
				default:
					lt_st_ff <= PRS_LT_QUIET;
			endcase
		end
	end

	always_comb
	begin
		case (lt_st_ff)
			PRS_LT_ACTIVE: ltssm_state = `PRS_LT_DACTIVE;
			PRS_LT_POLL:   ltssm_state = `PRS_LT_PACTIVE;
			default:       ltssm_state = `PRS_LT_DQUIET;
		endcase
	end

	// Receive digital reset is held outside polling, and in polling until signal detect has been stable for SIGDET_CYC cycles.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sd_cnt_ff  <= 32'h0;
			sd_prev_ff <= 1'b0;
		end
		else
		begin
			sd_prev_ff <= sd_sync_ff[1];
			if (lt_st_ff != PRS_LT_POLL || !sd_sync_ff[1] || sd_prev_ff != sd_sync_ff[1])
				sd_cnt_ff <= 32'h0;
			else if (sd_cnt_ff != SIGDET_CYC)
				sd_cnt_ff <= sd_cnt_ff + 32'h1;
		end
	end
	assign rx_digital_rst = (sd_cnt_ff != SIGDET_CYC);

	// Link status is sampled once the core is out of reset; the crossing from the PHY lies upstream.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			link_ff <= '0;
		else if (!core_rst)
			link_ff <= link_in;
	end

	// AHB-Lite slave: zero wait states, always OKAY.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_ph_ff   <= 1'b0;
			wr_addr_ff <= 16'h0;
		end
		else if (hready)
		begin
			wr_ph_ff   <= hsel && htrans[1] && hwrite;
			wr_addr_ff <= haddr;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ctrl_hold_ff <= 1'b0;
		else if (wr_ph_ff && wr_addr_ff == `PRS_OFS_CTRL)
			ctrl_hold_ff <= hwdata[0];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h0;
		else if (hready && hsel && htrans[1] && !hwrite)
		begin
			case (haddr)
				`PRS_OFS_SPEED: hrdata <= {30'h0, link_ff.speed};
				`PRS_OFS_LANE:  hrdata <= {28'h0, link_ff.lanes};
				`PRS_OFS_LTSSM: hrdata <= {27'h0, ltssm_state};
				`PRS_OFS_RESET: hrdata <= {27'h0, rx_digital_rst, tx_digital_rst, reset_status, core_rst, ~tx_xcvr_rst_n};
				`PRS_OFS_CTRL:  hrdata <= {31'h0, ctrl_hold_ff};
				default:        hrdata <= 32'h0;
			endcase
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Checker-only count of qualified cycles, kept apart from the sequencer so that
	// a miscount there cannot hide itself; it saturates one past the release point.
	logic [5:0]  chk_up_ff;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			chk_up_ff <= 6'h00;
		else if (!in_sync_ff[1] || ctrl_hold_ff)
			chk_up_ff <= 6'h00;
		else if (chk_up_ff != 6'(`PRS_CORE_DLY + 1))
			chk_up_ff <= chk_up_ff + 6'h01;
	end

	// Core reset ordering.
	a_core_hold: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!in_sync_ff[1] |=> core_rst)
		else $error("core reset released without clock in use");

	a_ctrl_hold: assert property (
		@(posedge hclk) disable iff (!hresetn)
		ctrl_hold_ff |=> core_rst)
		else $error("core reset released while software holds it");

	a_core_delay: assert property (
		@(posedge hclk) disable iff (!hresetn)
		$rose(in_sync_ff[1]) && !ctrl_hold_ff ##1 (in_sync_ff[1] && !ctrl_hold_ff) [*8] |-> core_rst)
		else $error("core reset released early");

	a_core_exact: assert property (
		@(posedge hclk) disable iff (!hresetn)
		core_rst == (chk_up_ff <= 6'(`PRS_CORE_DLY)))
		else $error("core reset release not at the counted cycle");

	a_status_follow: assert property (
		@(posedge hclk) disable iff (!hresetn)
		$fell(core_rst) |-> !reset_status)
		else $error("reset status not released");

	// Training state moves.
	a_det_active: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(lt_st_ff == PRS_LT_QUIET && rxl_sync_ff[1] && !core_rst) |=> ltssm_state == `PRS_LT_DACTIVE)
		else $error("no move to detect active");

	a_quiet_stay: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ltssm_state == `PRS_LT_DQUIET && !rxl_sync_ff[1]) |=> ltssm_state == `PRS_LT_DQUIET)
		else $error("left detect quiet without receive lock");

	a_active_stay: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(lt_st_ff == PRS_LT_ACTIVE && !core_rst && !(phystatus && rxstatus == `PRS_RXDET_DONE))
		|=> ltssm_state == `PRS_LT_DACTIVE)
		else $error("left detect active without detection");

	a_poll_entry: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ltssm_state == `PRS_LT_DACTIVE && phystatus && rxstatus == `PRS_RXDET_DONE && !core_rst)
		|=> ltssm_state == `PRS_LT_PACTIVE)
		else $error("no move to polling");

	a_ltssm_codes: assert property (
		@(posedge hclk) disable iff (!hresetn)
		ltssm_state inside {`PRS_LT_DQUIET, `PRS_LT_DACTIVE, `PRS_LT_PACTIVE})
		else $error("training state code outside the tracked set");

	a_ltssm_read: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(hready && hsel && htrans[1] && !hwrite && haddr == `PRS_OFS_LTSSM)
		|=> hrdata == {27'h0, $past(ltssm_state)})
		else $error("training state register does not follow the state");

	// Transceiver resets.
	a_rx_hold: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!sd_sync_ff[1] |=> rx_digital_rst)
		else $error("receive reset released without signal");

	a_rx_enter: assert property (
		@(posedge hclk) disable iff (!hresetn)
		($changed(ltssm_state) && ltssm_state == `PRS_LT_PACTIVE) |-> rx_digital_rst)
		else $error("receive reset not raised on entering polling");

	a_serdes_rst: assert property (
		@(posedge hclk) disable iff (!hresetn)
		tx_xcvr_rst_n)
		else $error("transmit transceiver reset held");

	a_tx_hold: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!lock_sync_ff[1] |=> tx_digital_rst [*3])
		else $error("transmit reset released early");

	a_tx_release: assert property (
		@(posedge hclk) disable iff (!hresetn)
		lock_sync_ff[1] [*8] |-> ##[0:130] (!tx_digital_rst || !lock_sync_ff[1]))
		else $error("transmit reset stuck");

	// Status capture and bus.
	a_link_hold: assert property (
		@(posedge hclk) disable iff (!hresetn)
		core_rst |=> $stable(link_ff))
		else $error("link status captured while core in reset");

	a_bus_okay: assert property (
		@(posedge hclk) disable iff (!hresetn)
		hreadyout && !hresp)
		else $error("bus answer not ready and okay");

	// Main scenarios to be seen at least once.
	c_core_out: cover property (@(posedge hclk) disable iff (!hresetn) $fell(core_rst));
	c_polling: cover property (@(posedge hclk) disable iff (!hresetn) ltssm_state == `PRS_LT_PACTIVE);
	c_tx_out: cover property (@(posedge hclk) disable iff (!hresetn) $fell(tx_digital_rst));
	c_rx_out: cover property (@(posedge hclk) disable iff (!hresetn) $fell(rx_digital_rst));
	c_ctrl_hold: cover property (@(posedge hclk) disable iff (!hresetn) $rose(ctrl_hold_ff));
endmodule : prs_top

// [verif/prs_app_rst.sv]
// Application-side reset generator that follows the core reset status.
`timescale 1ns/1ps
module prs_app_rst
	import prs_pkg::*;
(
	input  wire logic hclk,         // Fabric clock.
	input  wire logic hresetn,      // Power-on reset, active low.
	input  wire logic reset_status, // Core reset status.
	output logic      app_rst_n     // Application reset, active low.
);
	logic [5:0] cnt_ff;
	// Counting on the fabric clock alone keeps the release aligned to it.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			cnt_ff <= 6'h00;
		else if (reset_status)
			cnt_ff <= 6'h00;
		else if (cnt_ff != 6'h20)
			cnt_ff <= cnt_ff + 6'h01;
	end
	assign app_rst_n = (cnt_ff == 6'h20) && !reset_status;
endmodule : prs_app_rst

// [verif/tb.sv]
// Testbench for the reset sequencer and its status registers.
`timescale 1ns/1ps
module tb
	import prs_pkg::*;
;
	logic hclk = 0, hresetn = 0, perst_n = 0, clk_inuse = 0, rx_pll_locked = 0, pll_locked = 0;
	logic phystatus = 0, rx_sigdet = 0, hsel = 0, hwrite = 0, hready;
	logic [2:0] rxstatus = 3'h0, hsize = 3'h2;
	logic [15:0] haddr = 16'h0000;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 32'h0, hrdata, rd;
	prs_link_t link_in = 6'h00;
	logic core_rst, reset_status, tx_xcvr_rst_n, tx_digital_rst, rx_digital_rst, hreadyout, hresp, app_rst_n;
	logic [4:0] ltssm_state;
	int mismatches = 0, compares = 0, n;
	always #5 hclk = ~hclk;
	assign hready = hreadyout;
	prs_top #(.SIGDET_CYC(20)) prs_top_i (.hclk(hclk), .hresetn(hresetn), .perst_n(perst_n),
		.clk_inuse(clk_inuse), .rx_pll_locked(rx_pll_locked), .pll_locked(pll_locked), .phystatus(phystatus),
		.rxstatus(rxstatus), .rx_sigdet(rx_sigdet), .link_in(link_in), .core_rst(core_rst),
		.reset_status(reset_status), .tx_xcvr_rst_n(tx_xcvr_rst_n), .tx_digital_rst(tx_digital_rst),
		.rx_digital_rst(rx_digital_rst), .ltssm_state(ltssm_state), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp));
	prs_app_rst prs_app_rst_i (.hclk(hclk), .hresetn(hresetn), .reset_status(reset_status), .app_rst_n(app_rst_n));
	task finish_test();
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : finish_test
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	function automatic logic [4:0] pick(input int sel);
		case (sel)
			0: pick = {4'h0, core_rst};
			1: pick = {4'h0, tx_digital_rst};
			2: pick = {4'h0, rx_digital_rst};
			3: pick = {4'h0, app_rst_n};
			default: pick = ltssm_state;
		endcase
	endfunction : pick
	// Counts edges until the chosen output shows the value; a bound guards against a hang.
	task wait_val(input int sel, input logic [4:0] v, output int cnt);
		cnt = 0;
		while (pick(sel) !== v)
		begin
			@(posedge hclk);
			#1;
			cnt++;
			if (cnt > 400)
			begin
				mismatches++;
				finish_test();
			end
		end
	endtask : wait_val
	task wait_rdy();
		@(posedge hclk);
		#1;
		for (int i = 0; i < 50 && hreadyout !== 1'b1; i++)
		begin
			@(posedge hclk);
			#1;
		end
		if (hreadyout !== 1'b1)
		begin
			mismatches++;
			finish_test();
		end
	endtask : wait_rdy
	task xfer(input logic [15:0] a, input logic w, input logic [31:0] wd, output logic [31:0] r);
		haddr <= a;
		hwrite <= w;
		hsel <= 1'b1;
		htrans <= 2'h2;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		r = hrdata;
	endtask : xfer
	initial
	begin
		repeat (6) @(posedge hclk);
		chk("core reset", core_rst, 1);
		chk("xcvr reset", tx_xcvr_rst_n, 0);
		hresetn <= 1'b1;
		perst_n <= 1'b1;
		repeat (40) @(posedge hclk);
		#1;
		chk("xcvr release", tx_xcvr_rst_n, 1);
		chk("core held", core_rst, 1);
		clk_inuse <= 1'b1;
		wait_val(0, 0, n);
		chk("core delay ok", n >= 32 && n <= 37, 1);
		chk("status follows", reset_status, 0);
		wait_val(3, 1, n);
		chk("app delay ok", n >= 31 && n <= 33, 1);
		pll_locked <= 1'b1;
		repeat (60) @(posedge hclk);
		pll_locked <= 1'b0;
		repeat (4) @(posedge hclk);
		#1;
		chk("tx held", tx_digital_rst, 1);
		pll_locked <= 1'b1;
		wait_val(1, 0, n);
		chk("tx delay ok", n >= 127 && n <= 132, 1);
		chk("quiet", ltssm_state, 5'h00);
		rx_pll_locked <= 1'b1;
		wait_val(4, 5'h01, n);
		chk("det delay ok", n >= 2 && n <= 4, 1);
		for (int s = 2; s <= 3; s++)
		begin
			@(posedge hclk);
			phystatus <= 1'b1;
			rxstatus <= s[2:0];
			@(posedge hclk);
			phystatus <= 1'b0;
			repeat (4) @(posedge hclk);
			#1;
			chk("ltssm", ltssm_state, s == 3 ? 5'h03 : 5'h01);
		end
		chk("rx held", rx_digital_rst, 1);
		rx_sigdet <= 1'b1;
		wait_val(2, 0, n);
		chk("rx delay ok", n >= 20 && n <= 25, 1);
		for (int i = 0; i < 4; i++)
		begin
			link_in <= {i[1:0], 4'h1 << i};
			repeat (3) @(posedge hclk);
			xfer(16'h0068, 1'b1, 32'hffffffff, rd);
			xfer(16'h0068, 1'b0, 32'h0, rd);
			chk("speed", rd, i);
			xfer(16'h006c, 1'b0, 32'h0, rd);
			chk("lanes", rd, 32'h1 << i);
		end
		xfer(16'h0070, 1'b0, 32'h0, rd);
		chk("ltssm reg", rd, 32'h3);
		xfer(16'h007c, 1'b0, 32'h0, rd);
		chk("unmapped", rd, 32'h0);
		chk("resp", hresp, 0);
		xfer(16'h0074, 1'b0, 32'h0, rd);
		chk("reset reg", rd, 32'h0);
		xfer(16'h0078, 1'b1, 32'h1, rd);
		wait_val(0, 1, n);
		chk("hold delay ok", n <= 2, 1);
		chk("status again", reset_status, 1);
		chk("app held", app_rst_n, 0);
		xfer(16'h0078, 1'b0, 32'h0, rd);
		chk("ctrl reg", rd, 32'h1);
		xfer(16'h0078, 1'b1, 32'h0, rd);
		wait_val(0, 0, n);
		chk("core again ok", n >= 32 && n <= 37, 1);
		repeat (10) @(posedge hclk);
		xfer(16'h0078, 1'b1, 32'h1, rd);
		xfer(16'h0078, 1'b1, 32'h0, rd);
		chk("app restart held", app_rst_n, 0);
		wait_val(0, 0, n);
		wait_val(3, 1, n);
		chk("app restart ok", n >= 31 && n <= 33, 1);
		chk("ltssm after hold", ltssm_state, 5'h01);
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		#1;
		chk("core in reset", core_rst, 1);
		chk("xcvr in reset", tx_xcvr_rst_n, 0);
		chk("tx in reset", tx_digital_rst, 1);
		@(posedge hclk);
		hresetn <= 1'b1;
		xfer(16'h0078, 1'b0, 32'h0, rd);
		chk("ctrl after reset", rd, 32'h0);
		wait_val(0, 0, n);
		chk("core after reset ok", n >= 32 && n <= 37, 1);
		finish_test();
	end
endmodule : tb
